// file: verilog/rspc_framer.sv
// packet framer: sync qualifier, preamble, payload coding, channel offset, tx fifo
// Function
// - modes 000 and 100 send no sync word and search for none.
// - modes 1, 2, 5 and 6 send a 16-bit sync word and search for 16 bits.
// - modes 001 and 101 accept 15 of 16 matching bits, 010 and 110 need all 16.
// - modes 011 and 111 send the sync word twice and accept 30 of 32 bits.
// - mode 100 qualifies on carrier sense alone, 101 to 111 need carrier sense plus sync.
// - the sync mode field resets to 010.
// - the enable bit 7 turns on rate one half payload error coding, reset off.
// - bits 6:4 pick 2,3,4,6,8,12,16 or 24 preamble bytes, reset code 010.
// - the mantissa has an implied leading one, so the multiplier is 256 plus it, reset 0xF8.
// - the channel offset is the multiplier times two to the exponent times channel number.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "rspc_cfg.svh"

module rspc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("fifo depth must be a power of two");
    end
  endgenerate
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt;
  logic push, pop;
  assign push = inValid & rdy_r;
  assign pop = outReady & outValid;
  assign inReady = rdy_r;
  assign outValid = cnt_r != '0;
  assign outData = mem_r[rp_r];
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      mem_nxt[wp_r] = inData;
      wp_nxt = wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = rp_r + 1'b1;
    end
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    // ready is registered from the next count so it never overstates room
    rdy_nxt = cnt_nxt != CW'(DEPTH);
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end
endmodule

module rspc_framer
  import rspc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic txInValid,
  input wire rspc_word_s txInData,
  output logic txInReady,
  input wire logic txBitReq,
  output logic txBit,
  output logic txBitValid,
  output logic txActive,
  input wire logic rxEnable,
  input wire logic rxBitValid,
  input wire logic rxBit,
  input wire logic carrierSense,
  output logic [7:0] rxByte,
  output logic rxByteValid,
  output logic syncFound,
  output logic rxQualified,
  output logic [19:0] chanOffset
);
  function automatic logic [4:0] preBytes(input logic [2:0] c);
    case (c)
      3'h0: return 5'h02;
      3'h1: return 5'h03;
      3'h2: return 5'h04;
      3'h3: return 5'h06;
      3'h4: return 5'h08;
      3'h5: return 5'h0C;
      3'h6: return 5'h10;
      default: return 5'h18;
    endcase
  endfunction
  function automatic logic syncOn(input logic [2:0] m);
    return m[1:0] != 2'h0;
  endfunction
  function automatic logic sync32(input logic [2:0] m);
    return m[1:0] == 2'h3;
  endfunction
  function automatic logic [5:0] popErr(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction
  function automatic logic [5:0] tol(input logic [2:0] m);
    case (m[1:0])
      2'h1: return `RSPC_TOL_15OF16;
      2'h2: return `RSPC_TOL_16OF16;
      default: return `RSPC_TOL_30OF32;
    endcase
  endfunction
  // rate one half code, data bit then parity with the previous bit, msb first
  function automatic logic [16:0] fecEnc(input logic [7:0] d, input logic p);
    logic [15:0] c;
    logic q;
    c = 16'h0000;
    q = p;
    for (int i = 7; i >= 0; i--) begin
      c = {c[13:0], d[i], d[i] ^ q};
      q = d[i];
    end
    return {q, c};
  endfunction

  logic [2:0] syncMode_r, syncMode_nxt, preCode_r, preCode_nxt;
  logic fec_r, fec_nxt;
  logic [1:0] chanExp_r, chanExp_nxt;
  logic [7:0] mant_r, mant_nxt, channel_number_r, channel_number_nxt, rdData_r, rdData_nxt;
  logic [15:0] syncWord_r, syncWord_nxt;
  logic [19:0] chanOfs_r, chanOfs_nxt, effW;

  always_comb begin
    syncMode_nxt = syncMode_r;
    preCode_nxt = preCode_r;
    fec_nxt = fec_r;
    chanExp_nxt = chanExp_r;
    mant_nxt = mant_r;
    channel_number_nxt = channel_number_r;
    syncWord_nxt = syncWord_r;
    rdData_nxt = 8'h00;
    if (regWrite) begin
      case (regAddr)
        `RSPC_OFS_SYNC_MODE: syncMode_nxt = regWrData[`RSPC_MODE_MSB:0];
        `RSPC_OFS_FEC_PRE: begin
          fec_nxt = regWrData[`RSPC_FEC_BIT];
          preCode_nxt = regWrData[`RSPC_PRE_MSB:`RSPC_PRE_LSB];
          chanExp_nxt = regWrData[`RSPC_EXP_MSB:`RSPC_EXP_LSB];
        end
        `RSPC_OFS_MANT: mant_nxt = regWrData;
        `RSPC_OFS_SYNC_HI: syncWord_nxt[15:8] = regWrData;
        `RSPC_OFS_SYNC_LO: syncWord_nxt[7:0] = regWrData;
        `RSPC_OFS_CHANNEL_NUMBER: channel_number_nxt = regWrData;
        default: ;
      endcase
    end
    if (regRead) begin
      case (regAddr)
        `RSPC_OFS_SYNC_MODE: rdData_nxt = {5'h00, syncMode_r};
        `RSPC_OFS_FEC_PRE: rdData_nxt = {fec_r, preCode_r, 2'h0, chanExp_r};
        `RSPC_OFS_MANT: rdData_nxt = mant_r;
        `RSPC_OFS_SYNC_HI: rdData_nxt = syncWord_r[15:8];
        `RSPC_OFS_SYNC_LO: rdData_nxt = syncWord_r[7:0];
        `RSPC_OFS_CHANNEL_NUMBER: rdData_nxt = channel_number_r;
        `RSPC_OFS_STATUS: rdData_nxt = {5'h00, rxQualified, txActive, txInReady};
        default: rdData_nxt = 8'h00;
      endcase
    end
    effW = {11'h000, `RSPC_MANT_ONE + {1'b0, mant_r}};
    chanOfs_nxt = (effW << chanExp_r) * {12'h000, channel_number_r};
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncMode_r <= `RSPC_RST_SYNC_MODE;
      preCode_r <= `RSPC_RST_PRE;
      fec_r <= `RSPC_RST_FEC;
      chanExp_r <= `RSPC_RST_EXP;
      mant_r <= `RSPC_RST_MANT;
      channel_number_r <= `RSPC_RST_CHANNEL_NUMBER;
      syncWord_r <= `RSPC_RST_SYNC;
      rdData_r <= 8'h00;
      chanOfs_r <= 20'h0_0000;
    end else begin
      syncMode_r <= syncMode_nxt;
      preCode_r <= preCode_nxt;
      fec_r <= fec_nxt;
      chanExp_r <= chanExp_nxt;
      mant_r <= mant_nxt;
      channel_number_r <= channel_number_nxt;
      syncWord_r <= syncWord_nxt;
      rdData_r <= rdData_nxt;
      chanOfs_r <= chanOfs_nxt;
    end
  end
  assign regRdData = rdData_r;
  assign chanOffset = chanOfs_r;

  AST_CHANNEL_NUMBER: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ##1 chanOffset == 20'(({11'h000, $past(mant_r)} + 20'h0_0100) << $past(chanExp_r))
    * {12'h000, $past(channel_number_r)}) else $error("channel offset wrong");

  rspc_word_s fifoOut;
  logic fifoOutValid, fifoPop;
  rspc_fifo #(.WIDTH($bits(rspc_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .inValid(txInValid),
    .inData(txInData),
    .inReady(txInReady),
    .outValid(fifoOutValid),
    .outData(fifoOut),
    .outReady(fifoPop)
  );

  rspc_tx_e txState_r, txState_nxt;
  logic [15:0] txShift_r, txShift_nxt;
  logic [4:0] txBits_r, txBits_nxt, txBytes_r, txBytes_nxt;
  logic [2:0] txMode_r, txMode_nxt, txPre_r, txPre_nxt;
  logic txTwice_r, txTwice_nxt, txLast_r, txLast_nxt, txFec_r, txFec_nxt;
  logic fecPrev_r, fecPrev_nxt, txBit_r, txBit_nxt, txBv_r, txBv_nxt, txAct_r, txAct_nxt;
  logic [16:0] enc;

  always_comb begin
    txState_nxt = txState_r;
    txShift_nxt = txShift_r;
    txBits_nxt = txBits_r;
    txBytes_nxt = txBytes_r;
    txMode_nxt = txMode_r;
    txPre_nxt = txPre_r;
    txTwice_nxt = txTwice_r;
    txLast_nxt = txLast_r;
    txFec_nxt = txFec_r;
    fecPrev_nxt = fecPrev_r;
    txBit_nxt = txBit_r;
    txBv_nxt = 1'b0;
    txAct_nxt = txAct_r;
    fifoPop = 1'b0;
    enc = fecEnc(fifoOut.data, fecPrev_r);
    case (txState_r)
      TX_IDLE: if (fifoOutValid) begin
        // mode and coding are latched so a mid-packet write to them cannot tear a frame; the sync word is read live
        txState_nxt = TX_PRE;
        txShift_nxt = {`RSPC_PREAMBLE_BYTE, 8'h00};
        txBits_nxt = `RSPC_BITS_BYTE;
        txBytes_nxt = preBytes(preCode_r) - 5'h01;
        txMode_nxt = syncMode_r;
        txPre_nxt = preCode_r;
        txFec_nxt = fec_r;
        fecPrev_nxt = 1'b0;
        txAct_nxt = 1'b1;
      end
      TX_PRE, TX_SYNC, TX_DATA: if (txBitReq) begin
        txBit_nxt = txShift_r[15];
        txBv_nxt = 1'b1;
        txShift_nxt = {txShift_r[14:0], 1'b0};
        txBits_nxt = txBits_r - 5'h01;
        if (txBits_r == 5'h00) begin
          if (txState_r == TX_PRE && txBytes_r != 5'h00) begin
            txShift_nxt = {`RSPC_PREAMBLE_BYTE, 8'h00};
            txBits_nxt = `RSPC_BITS_BYTE;
            txBytes_nxt = txBytes_r - 5'h01;
          end else if (txState_r == TX_PRE && syncOn(txMode_r)) begin
            txState_nxt = TX_SYNC;
            txShift_nxt = syncWord_r;
            txBits_nxt = `RSPC_BITS_WORD;
            txTwice_nxt = sync32(txMode_r);
          end else if (txState_r == TX_SYNC && txTwice_r) begin
            txShift_nxt = syncWord_r;
            txBits_nxt = `RSPC_BITS_WORD;
            txTwice_nxt = 1'b0;
          end else if (txState_r == TX_DATA && txLast_r) begin
            txState_nxt = TX_IDLE;
            txAct_nxt = 1'b0;
          end else begin
            txState_nxt = TX_LOAD;
          end
        end
      end
      TX_LOAD: if (fifoOutValid) begin
        fifoPop = 1'b1;
        txState_nxt = TX_DATA;
        txLast_nxt = fifoOut.last;
        if (txFec_r) begin
          txShift_nxt = enc[15:0];
          txBits_nxt = `RSPC_BITS_WORD;
          fecPrev_nxt = enc[16];
        end else begin
          txShift_nxt = {fifoOut.data, 8'h00};
          txBits_nxt = `RSPC_BITS_BYTE;
        end
      end
      default: txState_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txState_r <= TX_IDLE;
      txShift_r <= 16'h0000;
      txBits_r <= 5'h00;
      txBytes_r <= 5'h00;
      txMode_r <= `RSPC_RST_SYNC_MODE;
      txPre_r <= `RSPC_RST_PRE;
      txTwice_r <= 1'b0;
      txLast_r <= 1'b0;
      txFec_r <= 1'b0;
      fecPrev_r <= 1'b0;
      txBit_r <= 1'b0;
      txBv_r <= 1'b0;
      txAct_r <= 1'b0;
    end else begin
      txState_r <= txState_nxt;
      txShift_r <= txShift_nxt;
      txBits_r <= txBits_nxt;
      txBytes_r <= txBytes_nxt;
      txMode_r <= txMode_nxt;
      txPre_r <= txPre_nxt;
      txTwice_r <= txTwice_nxt;
      txLast_r <= txLast_nxt;
      txFec_r <= txFec_nxt;
      fecPrev_r <= fecPrev_nxt;
      txBit_r <= txBit_nxt;
      txBv_r <= txBv_nxt;
      txAct_r <= txAct_nxt;
    end
  end
  assign txBit = txBit_r;
  assign txBitValid = txBv_r;
  assign txActive = txAct_r;

  // helper: preamble bits sent in the current frame
  logic [7:0] preCnt_r, preCnt_nxt;
  assign preCnt_nxt = (txState_r == TX_IDLE) ? 8'h00 :
    (txState_r == TX_PRE && txBitReq) ? preCnt_r + 8'h01 : preCnt_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      preCnt_r <= 8'h00;
    end else begin
      preCnt_r <= preCnt_nxt;
    end
  end

  AST_PRE_LEN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (txState_r == TX_PRE && txBitReq && txBits_r == 5'h00 && txBytes_r == 5'h00)
    |-> (preCnt_r + 8'h01) == {preBytes(txPre_r), 3'h0}) else $error("preamble length wrong");
  AST_NO_SYNC: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (txState_r == TX_PRE && !syncOn(txMode_r)) |=> txState_r != TX_SYNC)
    else $error("sync sent in a no-sync mode");
  AST_SYNC_LEN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (txState_r == TX_PRE ##1 txState_r == TX_SYNC) |-> txBits_r == `RSPC_BITS_WORD
    && txShift_r == $past(syncWord_r)) else $error("sync word not loaded whole");
  AST_SYNC_TWICE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (txState_r == TX_PRE ##1 txState_r == TX_SYNC) |-> txTwice_r == sync32(txMode_r))
    else $error("sync repeat wrong");
  AST_FEC_LEN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (txState_r == TX_LOAD ##1 txState_r == TX_DATA)
    |-> txBits_r == (txFec_r ? `RSPC_BITS_WORD : `RSPC_BITS_BYTE)) else $error("payload length wrong");

  rspc_rx_e rxState_r, rxState_nxt;
  logic [31:0] rxShift_r, rxShift_nxt;
  logic [5:0] rxSeen_r, rxSeen_nxt, rxErr16, rxErr32;
  logic [7:0] rxData_r, rxData_nxt, rxByte_r, rxByte_nxt;
  logic [2:0] rxCnt_r, rxCnt_nxt;
  logic rxPh_r, rxPh_nxt, rxBv_r, rxBv_nxt, sf_r, sf_nxt, rq_r, rq_nxt, csOk, hit;

  always_comb begin
    rxState_nxt = rxState_r;
    rxSeen_nxt = rxSeen_r;
    rxData_nxt = rxData_r;
    rxByte_nxt = rxByte_r;
    rxCnt_nxt = rxCnt_r;
    rxPh_nxt = rxPh_r;
    rxBv_nxt = 1'b0;
    sf_nxt = 1'b0;
    rq_nxt = rq_r;
    hit = 1'b0;
    rxShift_nxt = rxBitValid ? {rxShift_r[30:0], rxBit} : rxShift_r;
    rxErr16 = popErr({16'h0000, rxShift_nxt[15:0] ^ syncWord_r});
    rxErr32 = popErr(rxShift_nxt ^ {syncWord_r, syncWord_r});
    csOk = !syncMode_r[`RSPC_MODE_MSB] | carrierSense;
    case (rxState_r)
      RX_HUNT: begin
        if (rxBitValid && rxSeen_r != `RSPC_LEN32) begin
          rxSeen_nxt = rxSeen_r + 6'h01;
        end
        if (!syncOn(syncMode_r)) begin
          hit = csOk;
        end else if (rxBitValid && sync32(syncMode_r)) begin
          hit = csOk && rxSeen_nxt == `RSPC_LEN32 && rxErr32 <= `RSPC_TOL_30OF32;
        end else if (rxBitValid) begin
          hit = csOk && rxSeen_nxt >= `RSPC_LEN16 && rxErr16 <= tol(syncMode_r);
        end
        if (rxEnable && hit) begin
          rxState_nxt = RX_DATA;
          sf_nxt = 1'b1;
          rq_nxt = 1'b1;
          rxCnt_nxt = 3'h0;
          rxPh_nxt = 1'b0;
        end
      end
      RX_DATA: if (rxBitValid) begin
        // coded payload keeps the data bits, parity bits are only skipped
        rxPh_nxt = fec_r ? ~rxPh_r : 1'b0;
        if (!rxPh_r) begin
          rxData_nxt = {rxData_r[6:0], rxBit};
          rxCnt_nxt = rxCnt_r + 3'h1;
          if (rxCnt_r == 3'h7) begin
            rxByte_nxt = {rxData_r[6:0], rxBit};
            rxBv_nxt = 1'b1;
          end
        end
      end
      default: rxState_nxt = RX_HUNT;
    endcase
    if (!rxEnable) begin
      rxState_nxt = RX_HUNT;
      rq_nxt = 1'b0;
      rxSeen_nxt = 6'h00;
      sf_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxState_r <= RX_HUNT;
      rxShift_r <= 32'h0000_0000;
      rxSeen_r <= 6'h00;
      rxData_r <= 8'h00;
      rxByte_r <= 8'h00;
      rxCnt_r <= 3'h0;
      rxPh_r <= 1'b0;
      rxBv_r <= 1'b0;
      sf_r <= 1'b0;
      rq_r <= 1'b0;
    end else begin
      rxState_r <= rxState_nxt;
      rxShift_r <= rxShift_nxt;
      rxSeen_r <= rxSeen_nxt;
      rxData_r <= rxData_nxt;
      rxByte_r <= rxByte_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxPh_r <= rxPh_nxt;
      rxBv_r <= rxBv_nxt;
      sf_r <= sf_nxt;
      rq_r <= rq_nxt;
    end
  end
  assign rxByte = rxByte_r;
  assign rxByteValid = rxBv_r;
  assign syncFound = sf_r;
  assign rxQualified = rq_r;

  AST_EXACT16: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (syncFound && $past(syncMode_r[1:0]) == 2'h2) |-> rxShift_r[15:0] == $past(syncWord_r))
    else $error("inexact 16 bit sync accepted");
  AST_TOL16: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (syncFound && $past(syncMode_r[1:0]) == 2'h1)
    |-> popErr({16'h0000, rxShift_r[15:0] ^ $past(syncWord_r)}) <= `RSPC_TOL_15OF16)
    else $error("15 of 16 tolerance exceeded");
  AST_TOL32: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (syncFound && $past(syncMode_r[1:0]) == 2'h3)
    |-> popErr(rxShift_r ^ {2{$past(syncWord_r)}}) <= `RSPC_TOL_30OF32)
    else $error("30 of 32 tolerance exceeded");
  AST_CS_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (syncFound && $past(syncMode_r[2])) |-> $past(carrierSense))
    else $error("qualified without carrier sense");
endmodule

// file: verilog/rspc_cfg.svh
// register offsets, reset values, field positions and framing constants
`ifndef RSPC_CFG_SVH
`define RSPC_CFG_SVH
`define RSPC_OFS_SYNC_MODE 16'hDF0E
`define RSPC_OFS_FEC_PRE 16'hDF0F
`define RSPC_OFS_MANT 16'hDF10
`define RSPC_OFS_SYNC_HI 16'hDF20
`define RSPC_OFS_SYNC_LO 16'hDF21
`define RSPC_OFS_CHANNEL_NUMBER 16'hDF22
`define RSPC_OFS_STATUS 16'hDF23
`define RSPC_RST_SYNC_MODE 3'h2
`define RSPC_RST_FEC 1'h0
`define RSPC_RST_PRE 3'h2
`define RSPC_RST_EXP 2'h2
`define RSPC_RST_MANT 8'hF8
`define RSPC_RST_SYNC 16'h5A5A
`define RSPC_RST_CHANNEL_NUMBER 8'h00
`define RSPC_FEC_BIT 7
`define RSPC_PRE_MSB 6
`define RSPC_PRE_LSB 4
`define RSPC_EXP_MSB 1
`define RSPC_EXP_LSB 0
`define RSPC_MODE_MSB 2
`define RSPC_MANT_ONE 9'h100
`define RSPC_PREAMBLE_BYTE 8'hAA
`define RSPC_TOL_15OF16 6'h01
`define RSPC_TOL_16OF16 6'h00
`define RSPC_TOL_30OF32 6'h02
`define RSPC_LEN16 6'h10
`define RSPC_LEN32 6'h20
`define RSPC_BITS_BYTE 5'h07
`define RSPC_BITS_WORD 5'h0F
`endif

// file: verilog/rspc_pkg.sv
// types shared by the packet framer
package rspc_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_LOAD, TX_DATA} rspc_tx_e;
  typedef enum logic [0:0] {RX_HUNT, RX_DATA} rspc_rx_e;
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } rspc_word_s;
endpackage

// file: bench/rspc_remote_radio.sv
// remote radio model: pulls tx bits from the framer and sends rx bits to it
`timescale 1ns/1ps
module rspc_remote_radio (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic stall,
  input wire logic txActive,
  input wire logic txBit,
  input wire logic txBitValid,
  output logic txBitReq,
  output logic rxBitValid,
  output logic rxBit
);
  logic got[$];
  initial begin
    rxBitValid = 1'h0;
    rxBit = 1'h0;
  end
  // one request every other cycle; a stall keeps the frame parked in its preamble
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txBitReq <= 1'h0;
    end else begin
      txBitReq <= txActive && !stall && !txBitReq;
    end
  end
  always @(posedge sys_clk) begin
    if (txBitValid === 1'h1) begin
      got.push_back(txBit);
    end
  end
  // msb first; once idle the data line flips so a stale bit never looks valid
  task automatic sendBits(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk);
      rxBitValid <= 1'h1;
      rxBit <= w[i];
    end
    @(posedge sys_clk);
    rxBitValid <= 1'h0;
    rxBit <= ~rxBit;
  endtask
endmodule

// file: bench/rspc_framer_test.sv
// self-checking bench for the packet framer
`timescale 1ns/1ps
`include "rspc_cfg.svh"
module rspc_framer_test;
  import rspc_pkg::*;
  typedef struct packed {logic [15:0] a; logic [7:0] w; logic [7:0] r;} rspc_row_s;
  logic sys_clk, reset_n, regWrite, regRead, txInValid, txInReady, txBitReq, txBit;
  logic txBitValid, txActive, rxEnable, rxBitValid, rxBit, carrierSense, rxByteValid;
  logic syncFound, rxQualified, stall;
  logic [15:0] regAddr;
  logic [7:0] regWrData, regRdData, rxByte, lastByte, rdv;
  logic [19:0] chanOffset;
  rspc_word_s txInData;
  logic expQ[$];
  int mismatches, samples_checked, sfCount;
  // writes above the field width or to reserved/read-only places come back trimmed
  rspc_row_s rows[6] = '{
    '{`RSPC_OFS_SYNC_MODE, 8'hFF, 8'h07},
    '{`RSPC_OFS_FEC_PRE, 8'hF7, 8'hF3},
    '{`RSPC_OFS_MANT, 8'h00, 8'h00},
    '{`RSPC_OFS_CHANNEL_NUMBER, 8'h05, 8'h05},
    '{16'hDF11, 8'h3C, 8'h00},
    '{`RSPC_OFS_STATUS, 8'hFF, 8'h01}};

  rspc_framer rspc_framer_inst (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .txInValid(txInValid), .txInData(txInData), .txInReady(txInReady),
    .txBitReq(txBitReq), .txBit(txBit), .txBitValid(txBitValid), .txActive(txActive),
    .rxEnable(rxEnable), .rxBitValid(rxBitValid), .rxBit(rxBit),
    .carrierSense(carrierSense), .rxByte(rxByte), .rxByteValid(rxByteValid),
    .syncFound(syncFound), .rxQualified(rxQualified), .chanOffset(chanOffset));
  rspc_remote_radio rspc_remote_radio_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .stall(stall), .txActive(txActive), .txBit(txBit), .txBitValid(txBitValid),
    .txBitReq(txBitReq), .rxBitValid(rxBitValid), .rxBit(rxBit));

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (rxByteValid === 1'h1) lastByte <= rxByte;
  end
  always @(posedge sys_clk) begin
    if (syncFound === 1'h1) sfCount++;
  end

  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge sys_clk);
    regWrite <= 1'h0;
  endtask
  task rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge sys_clk);
    regRead <= 1'h0;
    #1 d = regRdData;
  endtask
  task push(input logic [7:0] d, input logic l);
    @(posedge sys_clk);
    txInValid <= 1'h1;
    txInData <= '{last: l, data: d};
    @(posedge sys_clk);
    txInValid <= 1'h0;
  endtask
  // expected air bits: preamble bytes, sync word(s), payload with optional parity bits
  task automatic runTx(input logic [2:0] m, input logic [2:0] c, input logic f, input int nb);
    int nPre[8] = '{2, 3, 4, 6, 8, 12, 16, 24};
    logic [7:0] b[$];
    logic p;
    int k, ns;
    wr(`RSPC_OFS_SYNC_MODE, {5'h00, m});
    wr(`RSPC_OFS_FEC_PRE, {f, c, 4'h2});
    rspc_remote_radio_inst.got.delete();
    stall <= (nb == 4);
    for (k = 0; k < nb; k++) begin
      b.push_back(8'h96 + k[7:0]);
      push(b[k], k == nb - 1);
    end
    if (nb == 4) begin
      repeat (2) @(posedge sys_clk);
      chk(20'(txInReady), 20'h0_0000);
      push(8'hFF, 1'h1);
      chk(20'(txInReady), 20'h0_0000);
      stall <= 1'h0;
    end
    k = 0;
    repeat (3) @(posedge sys_clk);
    while (txActive !== 1'h0 && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    // the radio logs the final bit on the edge that ends the loop
    repeat (2) @(posedge sys_clk);
    expQ.delete();
    p = 1'h0;
    ns = (m[1:0] == 2'h0) ? 0 : (m[1:0] == 2'h3) ? 32 : 16;
    for (int i = 0; i < nPre[c] * 8; i++) expQ.push_back(~i[0]);
    for (int i = 0; i < ns; i++) expQ.push_back(`RSPC_RST_SYNC >> (15 - i % 16) & 1);
    foreach (b[i]) for (int j = 7; j >= 0; j--) begin
      expQ.push_back(b[i][j]);
      if (f) expQ.push_back(b[i][j] ^ p);
      p = b[i][j];
    end
    chk(20'(rspc_remote_radio_inst.got.size()), 20'(expQ.size()));
    foreach (expQ[i]) chk(20'(rspc_remote_radio_inst.got[i]), 20'(expQ[i]));
    $display("tx test mode %0d code %0d fec %0d done", m, c, f);
  endtask
  task automatic rxCase(input logic [2:0] m, input logic [31:0] w, input int n,
      input logic cs, input logic q);
    int sf0;
    wr(`RSPC_OFS_SYNC_MODE, {5'h00, m});
    sf0 = sfCount;
    carrierSense <= cs;
    @(posedge sys_clk);
    rxEnable <= 1'h1;
    rspc_remote_radio_inst.sendBits(w, n);
    repeat (2) @(posedge sys_clk);
    chk(20'(rxQualified), 20'(q));
    chk(20'(sfCount - sf0), 20'(q));
    if (q) begin
      rspc_remote_radio_inst.sendBits({24'h00_0000, 5'h18, m}, 8);
      repeat (2) @(posedge sys_clk);
      chk(20'(lastByte), {12'h000, 5'h18, m});
    end
    @(posedge sys_clk);
    rxEnable <= 1'h0;
    carrierSense <= 1'h0;
    repeat (2) @(posedge sys_clk);
    $display("rx test mode %0d done", m);
  endtask

  initial begin
    #(2_000_000);
    mismatches++;
    give_verdict;
  end
  initial begin
    reset_n = 1'h0;
    {regWrite, regRead, txInValid, rxEnable, carrierSense, stall} = 6'h00;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    txInData = '0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'h1;
    rd(`RSPC_OFS_SYNC_MODE, rdv);
    chk(20'(rdv), 20'h0_0002);
    rd(`RSPC_OFS_FEC_PRE, rdv);
    chk(20'(rdv), 20'h0_0022);
    rd(`RSPC_OFS_MANT, rdv);
    chk(20'(rdv), 20'h0_00F8);
    chk(chanOffset, 20'h0_0000);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rdv);
      chk(20'(rdv), 20'(rows[i].r));
    end
    repeat (2) @(posedge sys_clk);
    chk(chanOffset, 20'h0_2800);
    wr(`RSPC_OFS_MANT, 8'h01);
    wr(`RSPC_OFS_FEC_PRE, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk(chanOffset, 20'h0_0505);
    $display("register table test done");
    runTx(3'h0, 3'h0, 1'h0, 1);
    runTx(3'h1, 3'h7, 1'h0, 1);
    runTx(3'h3, 3'h1, 1'h1, 2);
    runTx(3'h4, 3'h2, 1'h0, 1);
    runTx(3'h6, 3'h5, 1'h1, 1);
    runTx(3'h7, 3'h3, 1'h0, 4);
    wr(`RSPC_OFS_FEC_PRE, 8'h22);
    rxCase(3'h0, 32'h0000_0000, 0, 1'h0, 1'h1);
    rxCase(3'h4, 32'h0000_0000, 0, 1'h0, 1'h0);
    rxCase(3'h4, 32'h0000_0000, 0, 1'h1, 1'h1);
    rxCase(3'h1, 32'h0000_5E5A, 16, 1'h0, 1'h1);
    rxCase(3'h2, 32'h0000_5E5A, 16, 1'h0, 1'h0);
    rxCase(3'h2, 32'h0000_5A5A, 16, 1'h0, 1'h1);
    rxCase(3'h6, 32'h0000_5A5A, 16, 1'h0, 1'h0);
    rxCase(3'h5, 32'h0000_5A5B, 16, 1'h1, 1'h1);
    rxCase(3'h3, 32'h5A5A_5A48, 32, 1'h0, 1'h1);
    rxCase(3'h7, 32'h5A5D_5A5A, 32, 1'h1, 1'h0);
    // mid-run reset must restore every field, not only the power-up state
    @(posedge sys_clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
    rd(`RSPC_OFS_SYNC_MODE, rdv);
    chk(20'(rdv), 20'h0_0002);
    rd(`RSPC_OFS_MANT, rdv);
    chk(20'(rdv), 20'h0_00F8);
    rd(`RSPC_OFS_CHANNEL_NUMBER, rdv);
    chk(20'(rdv), 20'h0_0000);
    chk(chanOffset, 20'h0_0000);
    $display("mid-run reset test done");
    give_verdict;
  end
endmodule
